// ===== logic/loop_ctrl_pkg.sv
`default_nettype none
package loop_ctrl_pkg;
	// Timing
	localparam int CLK_FREQ_KHZ = 100000;
	localparam int PERIOD_FAST_MS = 100;
	localparam int PERIOD_SLOW_MS = 200;
	localparam int PERIOD_FAST_CYC = PERIOD_FAST_MS * CLK_FREQ_KHZ;
	localparam int PERIOD_SLOW_CYC = PERIOD_SLOW_MS * CLK_FREQ_KHZ;
	localparam int CNT_W = 32;

	// Datapath widths
	localparam int DATA_W = 16;
	localparam int INTEG_W = 24;
	localparam int ACC_W = 42;
	localparam int GAIN_SHIFT = 8;
	localparam int LOOPS = 2;
	localparam int GROUPS = 2;

	// Register byte addresses
	localparam logic [7:0] ADDR_CTRL = 8'h00;
	localparam logic [7:0] ADDR_THRESH = 8'h04;
	localparam logic [7:0] ADDR_CFG0 = 8'h08;
	localparam logic [7:0] ADDR_CFG1 = 8'h0C;
	localparam logic [7:0] ADDR_SP0 = 8'h10;
	localparam logic [7:0] ADDR_SP1 = 8'h14;
	localparam logic [7:0] ADDR_HYST0 = 8'h18;
	localparam logic [7:0] ADDR_HYST1 = 8'h1C;
	localparam logic [7:0] ADDR_GAIN_LO = 8'h20;
	localparam logic [7:0] ADDR_GAIN_HI = 8'h3C;
	localparam logic [7:0] ADDR_OUT = 8'h40;
	localparam logic [7:0] ADDR_STATUS = 8'h44;

	// CTRL field positions
	localparam int CTRL_MODE_LSB = 0;
	localparam int CTRL_SLOW_BIT = 2;
	localparam int CTRL_THRSW_BIT = 3;

	// Reset values
	localparam logic signed [15:0] KP_RESET = 16'h0100;
	localparam logic signed [15:0] KI_RESET = 16'h0000;
	localparam logic signed [15:0] KD_RESET = 16'h0000;
	localparam logic signed [15:0] ZERO16 = 16'h0000;

	typedef enum logic [1:0] {MODE_SINGLE, MODE_CASCADE, MODE_PV_SWITCH} ctrl_mode_e;
	typedef enum logic {TYPE_PID, TYPE_ONOFF} ctrl_type_e;
	typedef enum logic {PID_STANDARD, PID_FIXED_POINT} pid_mode_e;
	typedef enum logic {DERIV_PV, DERIV_DEVIATION} deriv_e;

	typedef struct packed {
		logic group;
		logic remote;
		pid_mode_e pid_mode;
		ctrl_type_e ctype;
	} loop_cfg_s;

	typedef struct packed {
		logic signed [15:0] ki;
		logic signed [15:0] kp;
	} gain_pair_s;

	typedef struct packed {
		deriv_e form;
		logic bumpless;
	} pid_form_s;

	localparam loop_cfg_s CFG_RESET = '{1'b0, 1'b0, PID_STANDARD, TYPE_PID};
endpackage
`default_nettype wire

// ===== logic/loop_ctrl_selector.sv
`timescale 1ns/10ps
`default_nettype none
module loop_ctrl_selector #(
	parameter int PERIOD_FAST_CYCLES = loop_ctrl_pkg::PERIOD_FAST_CYC,
	parameter int PERIOD_SLOW_CYCLES = loop_ctrl_pkg::PERIOD_SLOW_CYC
) (
	// Clock and reset
	input wire logic clk,
	input wire logic sys_rst,
	// Avalon-MM slave
	input wire logic [7:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	// Plant inputs
	input wire logic signed [15:0] analog_input_one,
	input wire logic signed [15:0] analog_input_two,
	input wire logic signed [15:0] remote_setpoint,
	input wire logic contact_input,
	// Plant outputs
	output logic signed [15:0] analog_output_one,
	output logic signed [15:0] analog_output_two,
	output logic onoff_output_one,
	output logic onoff_output_two,
	output logic control_tick
);

////////////////////////////////////////////////////////////////////////////////
// Helpers

function automatic logic [31:0] be_merge(logic [31:0] old, logic [31:0] nw, logic [3:0] be);
	logic [31:0] r;
	r = old;
	for (int i = 0; i < 4; i++) begin
		if (be[i]) begin
			r[i*8 +: 8] = nw[i*8 +: 8];
		end
	end
	return r;
endfunction

function automatic logic signed [15:0] sat16(logic signed [41:0] v);
	logic signed [41:0] hi;
	logic signed [41:0] lo;
	hi = 42'sh000_0000_7FFF;
	lo = -42'sh000_0000_8000;
	if (v > hi) begin
		return 16'sh7FFF;
	end else if (v < lo) begin
		return 16'sh8000;
	end
	return v[15:0];
endfunction

function automatic logic signed [23:0] sat24(logic signed [24:0] v);
	if (v[24] != v[23]) begin
		return v[24] ? 24'sh80_0000 : 24'sh7F_FFFF;
	end
	return v[23:0];
endfunction

// Form of the derivative and bump behaviour from the mode settings
function automatic loop_ctrl_pkg::pid_form_s form_of(loop_ctrl_pkg::ctrl_mode_e m,
		logic second, loop_ctrl_pkg::loop_cfg_s c);
	loop_ctrl_pkg::pid_form_s f;
	f.form = loop_ctrl_pkg::DERIV_PV;
	f.bumpless = 1'b0;
	if (c.remote) begin
		if (c.pid_mode == loop_ctrl_pkg::PID_STANDARD) begin
			f.form = loop_ctrl_pkg::DERIV_DEVIATION;
		end
	end else if (c.pid_mode == loop_ctrl_pkg::PID_FIXED_POINT) begin
		// Cascade primary keeps the bump even in fixed-point mode
		f.bumpless = !(m == loop_ctrl_pkg::MODE_CASCADE && !second);
	end
	return f;
endfunction

////////////////////////////////////////////////////////////////////////////////
// Registers

loop_ctrl_pkg::ctrl_mode_e mode_r;
logic slow_r;
logic thr_switch_r;
logic signed [15:0] thresh_r;
loop_ctrl_pkg::loop_cfg_s cfg_r [loop_ctrl_pkg::LOOPS];
logic signed [15:0] sp_r [loop_ctrl_pkg::LOOPS];
logic signed [15:0] hyst_pos_r [loop_ctrl_pkg::LOOPS];
logic signed [15:0] hyst_neg_r [loop_ctrl_pkg::LOOPS];
loop_ctrl_pkg::gain_pair_s gain_r [loop_ctrl_pkg::LOOPS*loop_ctrl_pkg::GROUPS];
logic signed [15:0] kd_r [loop_ctrl_pkg::LOOPS*loop_ctrl_pkg::GROUPS];
logic reinit_r;

logic signed [15:0] out_r [loop_ctrl_pkg::LOOPS];
logic onoff_r [loop_ctrl_pkg::LOOPS];
logic pv_sel_r;
loop_ctrl_pkg::pid_form_s form_c [loop_ctrl_pkg::LOOPS];

logic wr_go;
logic [31:0] cur_word;
logic [31:0] wr_word;
loop_ctrl_pkg::ctrl_mode_e new_mode;
logic [2:0] gidx;

// A request is taken at the edge where waitrequest is seen low
assign wr_go = avs_write && !avs_waitrequest;
assign wr_word = be_merge(cur_word, avs_writedata, avs_byteenable);
assign new_mode = loop_ctrl_pkg::ctrl_mode_e'(wr_word[loop_ctrl_pkg::CTRL_MODE_LSB +: 2]);
assign gidx = avs_address[5:3];

always_comb begin
	cur_word = 32'h0000_0000;
	unique case (avs_address)
		loop_ctrl_pkg::ADDR_CTRL: begin
			cur_word[loop_ctrl_pkg::CTRL_MODE_LSB +: 2] = mode_r;
			cur_word[loop_ctrl_pkg::CTRL_SLOW_BIT] = slow_r;
			cur_word[loop_ctrl_pkg::CTRL_THRSW_BIT] = thr_switch_r;
		end
		loop_ctrl_pkg::ADDR_THRESH: cur_word[15:0] = thresh_r;
		loop_ctrl_pkg::ADDR_CFG0: cur_word[3:0] = cfg_r[0];
		loop_ctrl_pkg::ADDR_CFG1: cur_word[3:0] = cfg_r[1];
		loop_ctrl_pkg::ADDR_SP0: cur_word[15:0] = sp_r[0];
		loop_ctrl_pkg::ADDR_SP1: cur_word[15:0] = sp_r[1];
		loop_ctrl_pkg::ADDR_HYST0: cur_word = {hyst_neg_r[0], hyst_pos_r[0]};
		loop_ctrl_pkg::ADDR_HYST1: cur_word = {hyst_neg_r[1], hyst_pos_r[1]};
		loop_ctrl_pkg::ADDR_OUT: cur_word = {out_r[1], out_r[0]};
		loop_ctrl_pkg::ADDR_STATUS: cur_word[6:0] = {pv_sel_r, form_c[1], form_c[0],
			onoff_r[1], onoff_r[0]};
		default: begin
			if (avs_address >= loop_ctrl_pkg::ADDR_GAIN_LO &&
					avs_address <= loop_ctrl_pkg::ADDR_GAIN_HI) begin
				cur_word = avs_address[2] ? {16'h0000, kd_r[gidx[1:0]]} : gain_r[gidx[1:0]];
			end
		end
	endcase
end

// One wait state on every access; unmapped reads return zero
always_ff @(posedge clk or posedge sys_rst) begin
	if (sys_rst) begin
		avs_waitrequest <= 1'b1;
		avs_readdata <= 32'h0000_0000;
	end else if ((avs_read || avs_write) && avs_waitrequest) begin
		avs_waitrequest <= 1'b0;
		// Writes leave the last read word in place
		if (avs_read) begin
			avs_readdata <= cur_word;
		end
	end else begin
		avs_waitrequest <= 1'b1;
	end
end

always_ff @(posedge clk or posedge sys_rst) begin
	if (sys_rst) begin
		mode_r <= loop_ctrl_pkg::MODE_SINGLE;
		slow_r <= 1'b0;
		thr_switch_r <= 1'b0;
		thresh_r <= loop_ctrl_pkg::ZERO16;
		reinit_r <= 1'b0;
		for (int l = 0; l < loop_ctrl_pkg::LOOPS; l++) begin
			cfg_r[l] <= loop_ctrl_pkg::CFG_RESET;
			sp_r[l] <= loop_ctrl_pkg::ZERO16;
			hyst_pos_r[l] <= loop_ctrl_pkg::ZERO16;
			hyst_neg_r[l] <= loop_ctrl_pkg::ZERO16;
		end
		for (int g = 0; g < loop_ctrl_pkg::LOOPS*loop_ctrl_pkg::GROUPS; g++) begin
			gain_r[g] <= '{loop_ctrl_pkg::KI_RESET, loop_ctrl_pkg::KP_RESET};
			kd_r[g] <= loop_ctrl_pkg::KD_RESET;
		end
	end else begin
		reinit_r <= 1'b0;
		if (wr_go && avs_address == loop_ctrl_pkg::ADDR_CTRL) begin
			slow_r <= wr_word[loop_ctrl_pkg::CTRL_SLOW_BIT];
			thr_switch_r <= wr_word[loop_ctrl_pkg::CTRL_THRSW_BIT];
			// The unused fourth code is ignored
			if (new_mode != mode_r && wr_word[1:0] != 2'b11) begin
				mode_r <= new_mode;
				reinit_r <= 1'b1;
				thresh_r <= loop_ctrl_pkg::ZERO16;
				for (int l = 0; l < loop_ctrl_pkg::LOOPS; l++) begin
					cfg_r[l] <= loop_ctrl_pkg::CFG_RESET;
					sp_r[l] <= loop_ctrl_pkg::ZERO16;
					hyst_pos_r[l] <= loop_ctrl_pkg::ZERO16;
					hyst_neg_r[l] <= loop_ctrl_pkg::ZERO16;
				end
				for (int g = 0; g < loop_ctrl_pkg::LOOPS*loop_ctrl_pkg::GROUPS; g++) begin
					gain_r[g] <= '{loop_ctrl_pkg::KI_RESET, loop_ctrl_pkg::KP_RESET};
					kd_r[g] <= loop_ctrl_pkg::KD_RESET;
				end
			end
		end else if (wr_go) begin
			unique case (avs_address)
				loop_ctrl_pkg::ADDR_THRESH: thresh_r <= wr_word[15:0];
				loop_ctrl_pkg::ADDR_CFG0: cfg_r[0] <= wr_word[3:0];
				loop_ctrl_pkg::ADDR_CFG1: cfg_r[1] <= wr_word[3:0];
				loop_ctrl_pkg::ADDR_SP0: sp_r[0] <= wr_word[15:0];
				loop_ctrl_pkg::ADDR_SP1: sp_r[1] <= wr_word[15:0];
				loop_ctrl_pkg::ADDR_HYST0: {hyst_neg_r[0], hyst_pos_r[0]} <= wr_word;
				loop_ctrl_pkg::ADDR_HYST1: {hyst_neg_r[1], hyst_pos_r[1]} <= wr_word;
				default: begin
					if (avs_address >= loop_ctrl_pkg::ADDR_GAIN_LO &&
							avs_address <= loop_ctrl_pkg::ADDR_GAIN_HI) begin
						if (avs_address[2]) begin
							kd_r[gidx[1:0]] <= wr_word[15:0];
						end else begin
							gain_r[gidx[1:0]] <= wr_word;
						end
					end
				end
			endcase
		end
	end
end

////////////////////////////////////////////////////////////////////////////////
// Control period divider

logic [loop_ctrl_pkg::CNT_W-1:0] cnt_r;
logic [loop_ctrl_pkg::CNT_W-1:0] cnt_last;
assign cnt_last = slow_r ? loop_ctrl_pkg::CNT_W'(PERIOD_SLOW_CYCLES - 1)
	: loop_ctrl_pkg::CNT_W'(PERIOD_FAST_CYCLES - 1);

always_ff @(posedge clk or posedge sys_rst) begin
	if (sys_rst) begin
		cnt_r <= '0;
		control_tick <= 1'b0;
	end else if (cnt_r >= cnt_last) begin
		cnt_r <= '0;
		control_tick <= 1'b1;
	end else begin
		cnt_r <= cnt_r + 1'b1;
		control_tick <= 1'b0;
	end
end

////////////////////////////////////////////////////////////////////////////////
// Loop computation

logic pv_sel_c;
logic signed [15:0] pv_c [loop_ctrl_pkg::LOOPS];
logic signed [15:0] sp_c [loop_ctrl_pkg::LOOPS];
logic signed [16:0] err_c [loop_ctrl_pkg::LOOPS];
logic signed [17:0] der_c [loop_ctrl_pkg::LOOPS];
logic signed [41:0] u_c [loop_ctrl_pkg::LOOPS];
logic onoff_c [loop_ctrl_pkg::LOOPS];
logic signed [16:0] dev_c [loop_ctrl_pkg::LOOPS];
logic signed [15:0] pv_prev_r [loop_ctrl_pkg::LOOPS];
logic signed [16:0] err_prev_r [loop_ctrl_pkg::LOOPS];
logic signed [15:0] sp_prev_r [loop_ctrl_pkg::LOOPS];
logic signed [23:0] integ_r [loop_ctrl_pkg::LOOPS];
logic signed [41:0] bias_r [loop_ctrl_pkg::LOOPS];
logic signed [41:0] bump_c [loop_ctrl_pkg::LOOPS];
loop_ctrl_pkg::gain_pair_s gsel;
logic signed [15:0] kdsel;

// PV2 takes over when the contact closes with the threshold switch clear, or with it set when PV1 reaches the threshold
assign pv_sel_c = thr_switch_r ? (analog_input_one >= thresh_r) : contact_input;

always_comb begin
	gsel = gain_r[0];
	kdsel = kd_r[0];
	for (int l = 0; l < loop_ctrl_pkg::LOOPS; l++) begin
		pv_c[l] = l == 0 ? analog_input_one : analog_input_two;
		if (l == 0 && mode_r == loop_ctrl_pkg::MODE_PV_SWITCH && pv_sel_c) begin
			pv_c[l] = analog_input_two;
		end
		sp_c[l] = sp_r[l];
		if (cfg_r[l].remote) begin
			sp_c[l] = (l == 1 && mode_r == loop_ctrl_pkg::MODE_CASCADE) ? out_r[0]
				: remote_setpoint;
		end
		form_c[l] = form_of(mode_r, l == 1, cfg_r[l]);
		err_c[l] = 17'(pv_c[l]) - 17'(sp_c[l]);
		if (form_c[l].form == loop_ctrl_pkg::DERIV_PV) begin
			der_c[l] = 18'(pv_c[l]) - 18'(pv_prev_r[l]);
		end else begin
			der_c[l] = 18'(err_c[l]) - 18'(err_prev_r[l]);
		end
		gsel = gain_r[l*loop_ctrl_pkg::GROUPS + int'(cfg_r[l].group)];
		kdsel = kd_r[l*loop_ctrl_pkg::GROUPS + int'(cfg_r[l].group)];
		// Bumpless: bias absorbs the proportional step of a setpoint change
		bump_c[l] = 42'(gsel.kp) * (42'(sp_c[l]) - 42'(sp_prev_r[l]));
		u_c[l] = 42'(gsel.kp) * 42'(err_c[l]) + 42'(gsel.ki) * 42'(integ_r[l])
			+ 42'(kdsel) * 42'(der_c[l]) + bias_r[l];
		// Cancel the step in the very period it appears, not one period late
		if (form_c[l].bumpless) begin
			u_c[l] = u_c[l] + bump_c[l];
		end
		dev_c[l] = 17'(sp_c[l]) - 17'(pv_c[l]);
		onoff_c[l] = onoff_r[l];
		if (dev_c[l] > 17'(hyst_pos_r[l])) begin
			onoff_c[l] = 1'b1;
		end else if (dev_c[l] < -17'(hyst_neg_r[l])) begin
			onoff_c[l] = 1'b0;
		end
	end
end

always_ff @(posedge clk or posedge sys_rst) begin
	if (sys_rst) begin
		pv_sel_r <= 1'b0;
		for (int l = 0; l < loop_ctrl_pkg::LOOPS; l++) begin
			out_r[l] <= loop_ctrl_pkg::ZERO16;
			onoff_r[l] <= 1'b0;
			pv_prev_r[l] <= loop_ctrl_pkg::ZERO16;
			err_prev_r[l] <= '0;
			sp_prev_r[l] <= loop_ctrl_pkg::ZERO16;
			integ_r[l] <= '0;
			bias_r[l] <= '0;
		end
	end else if (reinit_r) begin
		for (int l = 0; l < loop_ctrl_pkg::LOOPS; l++) begin
			out_r[l] <= loop_ctrl_pkg::ZERO16;
			sp_prev_r[l] <= loop_ctrl_pkg::ZERO16;
			pv_prev_r[l] <= loop_ctrl_pkg::ZERO16;
			err_prev_r[l] <= '0;
			onoff_r[l] <= 1'b0;
			integ_r[l] <= '0;
			bias_r[l] <= '0;
		end
	end else if (control_tick) begin
		pv_sel_r <= pv_sel_c;
		for (int l = 0; l < loop_ctrl_pkg::LOOPS; l++) begin
			pv_prev_r[l] <= pv_c[l];
			err_prev_r[l] <= err_c[l];
			sp_prev_r[l] <= sp_c[l];
			// The second loop idles while one loop runs on switched PV
			if (l == 1 && mode_r == loop_ctrl_pkg::MODE_PV_SWITCH) begin
				out_r[l] <= loop_ctrl_pkg::ZERO16;
				onoff_r[l] <= 1'b0;
			end else if (cfg_r[l].ctype == loop_ctrl_pkg::TYPE_ONOFF) begin
				onoff_r[l] <= onoff_c[l];
				out_r[l] <= loop_ctrl_pkg::ZERO16;
			end else begin
				onoff_r[l] <= 1'b0;
				integ_r[l] <= sat24(25'(integ_r[l]) + 25'(err_c[l]));
				out_r[l] <= sat16(u_c[l] >>> loop_ctrl_pkg::GAIN_SHIFT);
				if (form_c[l].bumpless) begin
					bias_r[l] <= bias_r[l] + bump_c[l];
				end
			end
		end
	end
end

always_ff @(posedge clk or posedge sys_rst) begin
	if (sys_rst) begin
		analog_output_one <= loop_ctrl_pkg::ZERO16;
		analog_output_two <= loop_ctrl_pkg::ZERO16;
		onoff_output_one <= 1'b0;
		onoff_output_two <= 1'b0;
	end else begin
		// In cascade the primary output only steers the secondary
		analog_output_one <= mode_r == loop_ctrl_pkg::MODE_CASCADE ? loop_ctrl_pkg::ZERO16
			: out_r[0];
		analog_output_two <= out_r[1];
		onoff_output_one <= onoff_r[0];
		onoff_output_two <= onoff_r[1];
	end
end

endmodule
`default_nettype wire

// ===== verification/loop_ctrl_chk.sv
`timescale 1ns/10ps
`default_nettype none
module loop_ctrl_chk #(
	parameter int PERIOD_FAST_CYCLES = 20,
	parameter int PERIOD_SLOW_CYCLES = 40
) (
	// Clock and reset
	input wire logic clk,
	input wire logic sys_rst,
	// Register bus
	input wire logic [7:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_readdata,
	input wire logic avs_waitrequest,
	// Plant side
	input wire logic signed [15:0] analog_output_one,
	input wire logic onoff_output_one,
	input wire logic control_tick
);
	default clocking @(posedge clk); endclocking
	default disable iff (sys_rst);
	int gap_r;
	logic seen_r;
	////////////////////////////////////////////////////////////////
	// Cycles since the last tick; only the upper bound is checked, a CTRL write clearing the slow bit may end a period early
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst)
			gap_r <= 0;
		else if (control_tick)
			gap_r <= 1;
		else
			gap_r <= gap_r + 1;
	end
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst)
			seen_r <= 1'b0;
		else if (control_tick)
			seen_r <= 1'b1;
	end
	////////////////////////////////////////////////////////////////
	wait_once_a: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
		else $error("bus access not answered after one wait state");
	wait_pulse_a: assert property (!avs_waitrequest |=> avs_waitrequest)
		else $error("waitrequest low for more than one cycle");
	wait_idle_a: assert property (!avs_read && !avs_write |=> avs_waitrequest)
		else $error("waitrequest low without a request");
	rdata_hold_a: assert property ($changed(avs_readdata) |-> $past(avs_read))
		else $error("read data changed without a read");
	unmapped_read_a: assert property (avs_read && !avs_waitrequest && avs_address == 8'h80
		|-> avs_readdata == 32'h00000000)
		else $error("unmapped address read nonzero");
	tick_pulse_a: assert property (control_tick |=> !control_tick)
		else $error("control tick longer than one cycle");
	tick_gap_a: assert property (control_tick && seen_r |-> gap_r <= PERIOD_SLOW_CYCLES)
		else $error("control period too long");
	onoff_hold_a: assert property ($changed(onoff_output_one) |-> $past(control_tick)
		|| $past(control_tick, 2) || $past(avs_write) || $past(avs_write, 2)
		|| $past(avs_write, 3))
		else $error("on/off output moved between ticks");
	out_hold_a: assert property ($changed(analog_output_one) |-> $past(control_tick)
		|| $past(control_tick, 2) || $past(control_tick, 3) || $past(avs_write)
		|| $past(avs_write, 2) || $past(avs_write, 3))
		else $error("control output moved between ticks");
endmodule
bind loop_ctrl_selector loop_ctrl_chk #(
	.PERIOD_FAST_CYCLES(PERIOD_FAST_CYCLES),
	.PERIOD_SLOW_CYCLES(PERIOD_SLOW_CYCLES)
) loop_ctrl_chk_inst (
	.clk(clk),
	.sys_rst(sys_rst),
	.avs_address(avs_address),
	.avs_read(avs_read),
	.avs_write(avs_write),
	.avs_readdata(avs_readdata),
	.avs_waitrequest(avs_waitrequest),
	.analog_output_one(analog_output_one),
	.onoff_output_one(onoff_output_one),
	.control_tick(control_tick)
);
`default_nettype wire

// ===== verification/plant_model.sv
`timescale 1ns/10ps
`default_nettype none
module plant_model (
	// Clock and reset
	input wire logic clk,
	input wire logic sys_rst,
	// Commanded plant state
	input wire logic signed [15:0] pv_one_set,
	input wire logic signed [15:0] pv_two_set,
	input wire logic contact_set,
	// Toward the device
	output logic signed [15:0] analog_input_one,
	output logic signed [15:0] analog_input_two,
	output logic signed [15:0] remote_setpoint,
	output logic contact_input
);
	// Sensors settle one clock after a command, like a real transmitter never instant
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			analog_input_one <= 16'sh0000;
			analog_input_two <= 16'sh0000;
			contact_input <= 1'b0;
		end else begin
			analog_input_one <= pv_one_set;
			analog_input_two <= pv_two_set;
			contact_input <= contact_set;
		end
	end
	assign remote_setpoint = 16'sh0000;
endmodule
`default_nettype wire

// ===== verification/loop_ctrl_selector_test.sv
`timescale 1ns/10ps
`default_nettype none
module loop_ctrl_selector_test;
	logic clk, sys_rst, avs_read, avs_write, avs_waitrequest, contact_input, contact_set;
	logic [7:0] avs_address;
	logic [31:0] avs_writedata, avs_readdata, q;
	logic [3:0] avs_byteenable;
	logic signed [15:0] ai_one, ai_two, rsp, out_one, out_two, pv_one_set, pv_two_set;
	logic onoff_one, onoff_two, control_tick;
	int mismatches, samples_checked, n;
	logic [15:0] pvs [6] = '{16'h0050, 16'h005F, 16'h0073, 16'h007D, 16'h0069, 16'h0055};
	logic ons [6] = '{1'b1, 1'b1, 1'b1, 1'b0, 1'b0, 1'b1};
	////////////////////////////////////////////////////////////////
	loop_ctrl_selector #(.PERIOD_FAST_CYCLES(20), .PERIOD_SLOW_CYCLES(40)) loop_ctrl_selector_inst (
		.clk(clk), .sys_rst(sys_rst), .avs_address(avs_address), .avs_read(avs_read),
		.avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
		.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
		.analog_input_one(ai_one), .analog_input_two(ai_two), .remote_setpoint(rsp),
		.contact_input(contact_input), .analog_output_one(out_one), .analog_output_two(out_two),
		.onoff_output_one(onoff_one), .onoff_output_two(onoff_two), .control_tick(control_tick));
	plant_model plant_model_inst (.clk(clk), .sys_rst(sys_rst), .pv_one_set(pv_one_set),
		.pv_two_set(pv_two_set), .contact_set(contact_set), .analog_input_one(ai_one),
		.analog_input_two(ai_two), .remote_setpoint(rsp), .contact_input(contact_input));
	////////////////////////////////////////////////////////////////
	task automatic test_done;
		$display("checks %0d mismatches %0d", samples_checked, mismatches);
		if (mismatches == 0 && samples_checked > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp) begin
			mismatches++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// One access; the extra edge after release keeps back-to-back calls from double driving
	task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] d);
		avs_address <= a;
		avs_writedata <= d;
		avs_write <= w;
		avs_read <= !w;
		do @(posedge clk); while (avs_waitrequest !== 1'b0);
		q = avs_readdata;
		avs_write <= 1'b0;
		avs_read <= 1'b0;
		@(posedge clk);
	endtask
	task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
		acc(1'b0, a, 32'h00000000);
		chk(q, exp);
	endtask
	task automatic tk(input int k);
		repeat (k) begin
			do @(posedge clk); while (control_tick !== 1'b1);
		end
		repeat (3) @(posedge clk);
	endtask
	task automatic gap(input int exp);
		tk(1);
		n = 3;
		do begin @(posedge clk); n++; end while (control_tick !== 1'b1);
		chk(n, exp);
	endtask
	////////////////////////////////////////////////////////////////
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	initial begin
		#200000;
		mismatches++;
		test_done();
	end
	initial begin
		{avs_read, avs_write, contact_set, sys_rst} = 4'h1;
		avs_address = 8'h00;
		avs_writedata = 32'h00000000;
		avs_byteenable = 4'hF;
		pv_one_set = 16'sh0000;
		pv_two_set = 16'sh0000;
		repeat (2) @(posedge clk);
		sys_rst <= 1'b0;
		@(posedge clk);
		rdchk(8'h00, 32'h00000000);
		rdchk(8'h08, 32'h00000000);
		rdchk(8'h0C, 32'h00000000);
		rdchk(8'h20, 32'h00000100);
		rdchk(8'h80, 32'h00000000);
		$display("test reset done");
		pv_one_set <= 16'sh0064;
		pv_two_set <= -16'sh0032;
		tk(2);
		chk({16'h0000, out_one}, 32'h00000064);
		chk({16'h0000, out_two}, 32'h0000FFCE);
		rdchk(8'h40, 32'hFFCE0064);
		acc(1'b1, 8'h28, 32'h00000200);
		acc(1'b1, 8'h08, 32'h00000008);
		tk(2);
		chk({16'h0000, out_one}, 32'h000000C8);
		$display("test pid done");
		// Mode, then fixed-point and remote bits; status holds {deriv, bumpless} per loop
		for (int m = 0; m < 3; m++) begin
			for (int c = 0; c < 4; c++) begin
				acc(1'b1, 8'h00, m);
				acc(1'b1, 8'h08, c << 1);
				acc(1'b1, 8'h0C, c << 1);
				tk(1);
				acc(1'b0, 8'h44, 32'h00000000);
				chk(q[3:2], {c == 2, m != 1 && c == 1});
				if (m == 1)
					chk(q[5:4], {c == 2, c == 1});
			end
		end
		$display("test derivative form done");
		acc(1'b1, 8'h00, 32'h00000000);
		acc(1'b1, 8'h08, 32'h00000001);
		acc(1'b1, 8'h0C, 32'h00000001);
		acc(1'b1, 8'h10, 32'h00000064);
		acc(1'b1, 8'h18, 32'h0014000A);
		for (int i = 0; i < 6; i++) begin
			pv_one_set <= pvs[i];
			tk(1);
			chk(onoff_one, ons[i]);
			chk({16'h0000, out_one}, 32'h00000000);
			chk(onoff_two, 1'b1);
		end
		$display("test on/off done");
		acc(1'b1, 8'h00, 32'h00000004);
		acc(1'b1, 8'h00, 32'h00000005);
		rdchk(8'h08, 32'h00000000);
		rdchk(8'h10, 32'h00000000);
		rdchk(8'h18, 32'h00000000);
		rdchk(8'h00, 32'h00000005);
		acc(1'b1, 8'h00, 32'h00000007);
		rdchk(8'h00, 32'h00000005);
		gap(40);
		// Secondary in cascade operation takes the primary output as setpoint
		acc(1'b1, 8'h0C, 32'h00000004);
		pv_one_set <= 16'sh0064;
		pv_two_set <= 16'sh0000;
		tk(3);
		chk({16'h0000, out_one}, 32'h00000000);
		chk({16'h0000, out_two}, 32'h0000FF9C);
		acc(1'b1, 8'h00, 32'h00000000);
		gap(20);
		$display("test mode change done");
		acc(1'b1, 8'h00, 32'h00000002);
		acc(1'b1, 8'h08, 32'h00000001);
		acc(1'b1, 8'h10, 32'h00000064);
		pv_one_set <= 16'sh0000;
		pv_two_set <= 16'sh00C8;
		for (int i = 0; i < 4; i++) begin
			contact_set <= i[0];
			if (i == 2) begin
				acc(1'b1, 8'h00, 32'h0000000A);
				acc(1'b1, 8'h04, 32'h00000032);
			end
			if (i == 3)
				pv_one_set <= 16'sh003C;
			tk(1);
			chk(onoff_one, i[0] == 1'b0 || i == 2);
			acc(1'b0, 8'h44, 32'h00000000);
			chk(q[6], i == 1 || i == 3);
		end
		$display("test pv switch done");
		// Fixed-point local: a setpoint step must not move the output at all
		acc(1'b1, 8'h00, 32'h00000000);
		acc(1'b1, 8'h08, 32'h00000002);
		pv_one_set <= 16'sh0064;
		tk(2);
		chk({16'h0000, out_one}, 32'h00000064);
		acc(1'b1, 8'h10, 32'h00000032);
		tk(1);
		chk({16'h0000, out_one}, 32'h00000064);
		$display("test bumpless done");
		test_done();
	end
endmodule
`default_nettype wire
